// File: design/rtcis_pkg.sv
// shared constants, states and carriers for the serial slave port of the clock chip
// assumes a single 200 MHz core clock and a sampled two-wire link
// Operation
// RULE1: single write: address byte, memory address, data, stop
// RULE2: device acknowledges every byte the master writes; the code nacks a data byte while the write buffer is full
// RULE3: multi write: data bytes stored one after another
// RULE4: reads start at internal address counter
// RULE5: single read: read address, one byte, nack
// RULE6: address-only write presets the address counter
// RULE7: repeated start after address phase begins read
// RULE8: device keeps sending while master acknowledges
// RULE9: master nack ends read, device releases data
// RULE10: device never holds the clock line low
// RULE11: data line only pulled low or released
// RULE12: responds only to address bytes D0h/D1h
// RULE13: foreign address ignored until next start
// RULE14: first byte after address is memory address
// RULE15: sample on clock rise, shift after fall
// RULE16: address counter increments after every data byte; the code leaves it unchanged for a data byte refused by a full buffer
package rtcis_pkg;

  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_W     = 16;

  // seven-bit device address: D0h for writes, D1h for reads
  localparam logic [6:0] SLAVE_ADDR  = 7'h68;
  localparam logic       DIR_READ    = 1'h1;
  localparam logic [3:0] BIT_LAST    = 4'h8;
  localparam logic [3:0] BIT_ZERO    = 4'h0;
  localparam logic [7:0] PTR_RESET   = 8'h00;
  localparam logic [7:0] PTR_STEP    = 8'h01;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_RECV   = 3'h1,
    ST_ACK    = 3'h2,
    ST_SEND   = 3'h3,
    ST_MACK   = 3'h4,
    ST_IGNORE = 3'h5
  } rtcis_state_type;

  typedef enum logic [1:0] {
    KIND_DEV  = 2'h0,
    KIND_MEM  = 2'h1,
    KIND_DATA = 2'h2
  } rtcis_kind_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } rtcis_wr_type;

endpackage

// File: design/rtcis_slave.sv
// serial slave port: two-wire link front end, address counter and write buffer
// assumes scl/sda arrive asynchronously and the memory answers rd_data_i combinationally

module rtcis_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp;
  logic [PW-1:0]    rp;
  logic [CW-1:0]    cnt;
  logic             push;
  logic             load;

  // output stage is a register so the consumer sees flop-driven data
  assign in_ready_o = (cnt != FULL_CNT);
  assign push       = in_valid_i & in_ready_o;
  assign load       = (cnt != '0) & (~out_valid_o | out_ready_i);

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wp] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= PW'(wp + 1'b1);
      end
      if (load) begin
        rp <= PW'(rp + 1'b1);
      end
      cnt <= CW'(cnt + CW'(push) - CW'(load));
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (load) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem[rp];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule // rtcis_fifo

module rtcis_slave (
  input  wire logic                  core_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_n_o,
  output logic                       wr_valid_o,
  input  wire logic                  wr_ready_i,
  output rtcis_pkg::rtcis_wr_type    wr_data_o,
  output logic                [7:0]  rd_addr_o,
  input  wire logic           [7:0]  rd_data_i,
  output logic                       busy_o
);
  logic                        scl_m;
  logic                        scl_s;
  logic                        scl_d;
  logic                        sda_m;
  logic                        sda_s;
  logic                        sda_d;
  rtcis_pkg::rtcis_state_type  st;
  rtcis_pkg::rtcis_kind_type   kind;
  logic [3:0]                  cnt;
  logic [7:0]                  rx;
  logic [7:0]                  tx;
  logic                        rw;
  logic                        mack;
  logic                        rise;
  logic                        fall;
  logic                        start;
  logic                        stop;
  logic                        byte_done;
  logic                        ack_ok;
  logic                        ack_end;
  logic                        mack_fall;
  logic                        load_tx;
  logic                        send_fall;
  logic                        push;
  logic                        fifo_ready;
  rtcis_pkg::rtcis_wr_type     push_word;
  logic [15:0]                 fifo_out;

  // the eighth bit of a byte has been clocked once the counter reaches its end value
  function automatic logic last_bit(input logic [3:0] count);
    return count == rtcis_pkg::BIT_LAST;
  endfunction

  // two-stage synchronisers plus a delay stage; the second and third stages feed logic
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  assign rise      = scl_s & ~scl_d;
  assign fall      = ~scl_s & scl_d;
  // start and stop are data edges while the clock stays high
  assign start     = scl_s & scl_d & sda_d & ~sda_s;
  assign stop      = scl_s & scl_d & ~sda_d & sda_s;
  assign byte_done = (st == rtcis_pkg::ST_RECV) & fall & last_bit(cnt);
  assign ack_end   = (st == rtcis_pkg::ST_ACK) & fall;
  assign send_fall = (st == rtcis_pkg::ST_SEND) & fall;
  assign mack_fall = (st == rtcis_pkg::ST_MACK) & fall;
  // read data is fetched at the counter, never at a byte sent with the read
  assign load_tx   = (ack_end & rw & (kind == rtcis_pkg::KIND_DEV)) | (mack_fall & mack); // RULE4 RULE8
  assign push      = byte_done & (kind == rtcis_pkg::KIND_DATA) & fifo_ready;

  always_comb begin
    case (kind)
      rtcis_pkg::KIND_DEV:  ack_ok = (rx[7:1] == rtcis_pkg::SLAVE_ADDR); // RULE12
      rtcis_pkg::KIND_MEM:  ack_ok = 1'b1;
      // a full buffer is answered with a nack rather than losing the byte
      rtcis_pkg::KIND_DATA: ack_ok = fifo_ready; // RULE2
      default:              ack_ok = 1'b0;
    endcase
  end

  // byte framing and transaction phase
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st   <= rtcis_pkg::ST_IDLE;
      kind <= rtcis_pkg::KIND_DEV;
      cnt  <= rtcis_pkg::BIT_ZERO;
      rx   <= '0;
    end else if (start) begin
      // a repeated start restarts framing from any phase
      st   <= rtcis_pkg::ST_RECV; // RULE7 RULE13
      kind <= rtcis_pkg::KIND_DEV;
      cnt  <= rtcis_pkg::BIT_ZERO;
    end else if (stop) begin
      st <= rtcis_pkg::ST_IDLE;
    end else begin
      case (st)
        rtcis_pkg::ST_RECV: begin
          if (rise) begin
            rx  <= {rx[6:0], sda_s}; // RULE15
            cnt <= 4'(cnt + 1'b1);
          end else if (byte_done) begin
            st <= ack_ok ? rtcis_pkg::ST_ACK : rtcis_pkg::ST_IGNORE; // RULE13
          end
        end
        rtcis_pkg::ST_ACK: begin
          if (fall) begin
            cnt <= rtcis_pkg::BIT_ZERO;
            if (load_tx) begin
              st <= rtcis_pkg::ST_SEND;
            end else begin
              st <= rtcis_pkg::ST_RECV;
              // byte after the address byte is always the memory address
              kind <= (kind == rtcis_pkg::KIND_DEV) ? rtcis_pkg::KIND_MEM : rtcis_pkg::KIND_DATA; // RULE14 RULE3
            end
          end
        end
        rtcis_pkg::ST_SEND: begin
          if (rise) begin
            cnt <= 4'(cnt + 1'b1);
          end else if (fall && last_bit(cnt)) begin
            st <= rtcis_pkg::ST_MACK;
          end
        end
        rtcis_pkg::ST_MACK: begin
          if (fall) begin
            cnt <= rtcis_pkg::BIT_ZERO;
            st  <= mack ? rtcis_pkg::ST_SEND : rtcis_pkg::ST_IGNORE; // RULE8 RULE9 RULE5
          end
        end
        rtcis_pkg::ST_IDLE,
        rtcis_pkg::ST_IGNORE: begin
          st <= st;
        end
        default: begin
          st <= rtcis_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // transfer direction is taken from the address byte only
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rw <= 1'b0;
    end else if (byte_done && kind == rtcis_pkg::KIND_DEV) begin
      rw <= rx[0];
    end
  end

  // master answer to a read byte, sampled on the rise of the ninth clock
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mack <= 1'b0;
    end else if (st == rtcis_pkg::ST_MACK && rise) begin
      mack <= ~sda_s; // RULE8
    end
  end

  // transmit shifter
  // limitation: the byte is fetched at its first bit, so a later write to it is not seen
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx <= '0;
    end else if (load_tx) begin
      tx <= rd_data_i; // RULE4
    end else if (send_fall && !last_bit(cnt)) begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  // open-drain data pin: the driven level is always low, high comes from the pullup
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sda_o      <= 1'b0; // RULE11
      sda_oe_n_o <= 1'b1;
    end else if (start || stop) begin
      sda_oe_n_o <= 1'b1;
    end else if (byte_done) begin
      sda_oe_n_o <= ~ack_ok; // RULE2
    end else if (ack_end || mack_fall) begin
      // bit 7 goes out right after the falling edge that ends the previous slot
      sda_oe_n_o <= load_tx ? rd_data_i[7] : 1'b1; // RULE15 RULE9
    end else if (send_fall) begin
      sda_oe_n_o <= last_bit(cnt) ? 1'b1 : tx[6]; // RULE11
    end
  end

  // address counter: preset by the memory address byte, stepped per stored or sent data byte
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rd_addr_o <= rtcis_pkg::PTR_RESET;
    end else if (byte_done && kind == rtcis_pkg::KIND_MEM) begin
      rd_addr_o <= rx; // RULE6 RULE1
    end else if (push || (send_fall && last_bit(cnt))) begin
      rd_addr_o <= 8'(rd_addr_o + rtcis_pkg::PTR_STEP); // RULE16
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (st != rtcis_pkg::ST_IDLE) && (st != rtcis_pkg::ST_IGNORE);
    end
  end

  assign push_word.addr = rd_addr_o;
  assign push_word.data = rx;
  assign wr_data_o      = rtcis_pkg::rtcis_wr_type'(fifo_out);

  // the clock pin is input only, so no stretching is ever possible
  rtcis_fifo #(
    .WIDTH (rtcis_pkg::FIFO_W),
    .DEPTH (rtcis_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (push), // RULE1 RULE3
    .in_ready_o  (fifo_ready),
    .in_data_i   (push_word),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (fifo_out)
  ); // RULE10
endmodule // rtcis_slave

// File: tb/rtcis_master_model.sv
// bus master model for the two-wire link: start, stop, byte out, byte in
// assumes a pull-up resolves sda_i; the clock stands high between frames
module rtcis_master_model (
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  int lo_extra = 0;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // push-pull clock, never read back, since the slave cannot stretch it
  task automatic clk_bit(input logic b, output logic s);
    scl_o = 1'b0;
    #12 sda_o = b;
    #(24 + lo_extra) scl_o = 1'b1;
    #6 s = sda_i;
    #6;
  endtask
  task automatic start_c(input logic rep);
    if (rep) begin
      scl_o = 1'b0;
      #24 sda_o = 1'b1;
      #12 scl_o = 1'b1;
    end
    #12 sda_o = 1'b0;
    #12;
  endtask
  task automatic stop_c();
    scl_o = 1'b0;
    #12 sda_o = 1'b0;
    #24 scl_o = 1'b1;
    #12 sda_o = 1'b1;
    #24;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, ack_n);
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
    clk_bit(nack, s);
  endtask
endmodule // rtcis_master_model

// File: tb/rtcis_slave_monitor.sv
// checker for the serial slave port, bound to every rtcis_slave
// assumes the link pins change between core clock edges
module rtcis_monitor (
  input wire logic                    core_clk_i,
  input wire logic                    sys_rst_i,
  input wire logic                    scl_i,
  input wire logic                    sda_i,
  input wire logic                    sda_o,
  input wire logic                    sda_oe_n_o,
  input wire logic                    wr_valid_o,
  input wire logic                    wr_ready_i,
  input wire rtcis_pkg::rtcis_wr_type wr_data_o,
  input wire logic              [7:0] rd_addr_o,
  input wire logic              [7:0] rd_data_i,
  input wire logic                    busy_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence start_seq;
    scl_i && $fell(sda_i);
  endsequence
  sequence stop_seq;
    scl_i && $rose(sda_i);
  endsequence
  AST_ODRAIN: assert property (!sda_oe_n_o |-> !sda_o) else $error("data driven high");
  AST_OE_LOW: assert property ($changed(sda_oe_n_o) |-> !scl_i) else $error("data moved, clock high");
  AST_START_REL: assert property (start_seq |-> sda_oe_n_o) else $error("data held at start");
  AST_STOP_REL: assert property (stop_seq |-> sda_oe_n_o) else $error("data held at stop");
  AST_STOP_IDLE: assert property (stop_seq |-> ##[1:8] !busy_o) else $error("busy after stop");
  AST_WR_HOLD: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_data_o))
    else $error("write word dropped");
  AST_WR_CAUSE: assert property ($rose(wr_valid_o) |-> $past(busy_o, 2)) else $error("stray write");
  AST_PTR_TXN: assert property ($changed(rd_addr_o) |-> busy_o || $past(busy_o))
    else $error("counter moved while idle");
endmodule // rtcis_monitor
bind rtcis_slave rtcis_monitor u_rtcis_monitor (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
  .wr_data_o(wr_data_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i), .busy_o(busy_o));

// File: tb/tb_top.sv
// bench for the serial slave port: random writes, preset reads, refusals, full buffer
// assumes the master model on the link and a memory behind both data ports
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    core_clk_i = 1'b0;
  logic                    sys_rst_i = 1'b1;
  logic                    wr_ready_i = 1'b0;
  logic                    stall = 1'b0;
  logic                    scl, m_sda, sda_w, sda_o, sda_oe_n_o, wr_valid_o, busy_o;
  rtcis_pkg::rtcis_wr_type wr_data_o;
  logic              [7:0] rd_addr_o, rd_data_i, mem [256], ref_mem [256];
  integer                  seed = 32'hB91791BE;
  int                      fails = 0, n_compared = 0, cycles = 0;
  // open-drain wire with pull-up
  assign sda_w = (sda_oe_n_o === 1'b0 || !m_sda) ? 1'b0 : 1'b1;
  assign rd_data_i = mem[rd_addr_o];
  rtcis_slave u_rtcis_slave (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
    .wr_data_o(wr_data_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i), .busy_o(busy_o));
  rtcis_master_model u_rtcis_master_model (.scl_o(scl), .sda_o(m_sda), .sda_i(sda_w));
  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  always @(negedge core_clk_i) begin
    wr_ready_i <= !stall && ($random(seed) % 3 != 0);
  end
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (wr_valid_o === 1'b1 && wr_ready_i) begin
      mem[wr_data_o.addr] <= wr_data_o.data;
    end
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic put(input logic [7:0] b, input logic exp_nack);
    logic a;
    u_rtcis_master_model.put_byte(b, a);
    cmp_byte("ack bit", {7'h00, exp_nack}, {7'h00, a});
  endtask
  task automatic wr_txn(input logic [7:0] a, input int n);
    logic [7:0] d;
    u_rtcis_master_model.start_c(1'b0);
    put(8'hD0, 1'b0);
    put(a, 1'b0);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      ref_mem[8'(a + i)] = d;
      put(d, 1'b0);
    end
  endtask
  task automatic rd_txn(input logic rep, input logic [7:0] a, input int n);
    logic [7:0] d;
    u_rtcis_master_model.start_c(rep);
    put(8'hD1, 1'b0);
    for (int i = 0; i < n; i++) begin
      u_rtcis_master_model.get_byte(i == n - 1, d);
      cmp_byte("read data", ref_mem[8'(a + i)], d);
    end
    u_rtcis_master_model.stop_c();
  endtask
  task automatic wait_drain();
    for (int i = 0; i < 100 && wr_valid_o !== 1'b0; i++) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] a;
    logic [7:0] bad [3] = '{8'hD2, 8'h68, 8'hC0};
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($random(seed));
      ref_mem[i] = mem[i];
    end
    repeat (10) @(posedge core_clk_i);
    @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    repeat (8) @(negedge core_clk_i);
    // last pass wraps the counter past FFh; one pass runs a slow clock
    for (int k = 0; k < 4; k++) begin
      a = (k == 3) ? 8'hFE : 8'($random(seed));
      u_rtcis_master_model.lo_extra = (k == 1) ? 40 : 0;
      wr_txn(a, k + 1);
      u_rtcis_master_model.stop_c();
      wr_txn(a, 0);
      rd_txn(1'b1, a, k + 1);
    end
    rd_txn(1'b0, 8'h02, 1);
    for (int i = 0; i < 3; i++) begin
      u_rtcis_master_model.start_c(1'b0);
      put(bad[i], 1'b1);
      put(8'h33, 1'b1);
      u_rtcis_master_model.stop_c();
      cmp_byte("counter", 8'h03, rd_addr_o);
    end
    // consumer stalled: 16 queued plus the output word, the next byte is refused
    wait_drain();
    stall = 1'b1;
    wr_txn(8'h40, 17);
    put(8'h5A, 1'b1);
    u_rtcis_master_model.stop_c();
    stall = 1'b0;
    wait_drain();
    for (int i = 0; i < 256; i++) cmp_byte("memory", ref_mem[i], mem[i]);
    tally_and_finish();
  end
endmodule // tb_top
